/* logic/instruction_word_decoder.sv */
`include "instruction_word_decoder_cfg.svh"

// Notes on behaviour
// RULE1: Each single word is 24 bits; the top 8 bits are the opcode.
// RULE2: Exactly three opcodes take two words, 48 bits; all others take one.
// RULE3: The second word of a double-word instruction has its upper 8 bits zero.
// RULE4: A second word executed alone decodes as no operation.
// RULE5: Register word/byte ops give base, second source and destination fields.
// RULE6: File ops give file address and a selector: file or working register zero.
// RULE7: Bit ops name register or file; bit from literal or base register.
// RULE8: Literal moves give a literal and a register or file target.
// RULE9: Literal ALU uses base and literal; destination only when different.
// RULE10: MAC ops pick accumulator, multiplicands, prefetches and write-back.
// RULE11: Other DSP ops pick accumulator, operand with modifier, shift source.
// RULE12: Control ops may give a program address and a table mode.
// RULE13: One instruction cycle is four clock periods.
// RULE14: Cycle clock output is low for two phases, high for two.
// RULE15: External timer edge increments the counter 0.5 to 1.5 cycles later.
// RULE16: After a double-word opcode the next word is operand data, not decoded.
module instruction_word_decoder #(
    parameter int WORD_W = `IWD_WORD_W
) (
    input  wire logic                        mclk,
    input  wire logic                        nrst,
    input  wire logic                        clk_en,
    input  wire logic [WORD_W-1:0]           fetch_word,
    input  wire logic                        fetch_valid,
    input  wire logic                        timer_external_clock_input,
    output logic                             cycle_clock_output,
    output logic [1:0]                       quarter_phase,
    output logic                             decode_valid,
    output instruction_word_decoder_pkg::instr_class_e instr_class,
    output logic [`IWD_OPC_W-1:0]            opcode,
    output logic                             double_word,
    output logic [WORD_W-1:0]                second_word,
    output logic                             second_word_bad,
    output logic [`IWD_REG_W-1:0]            base_source_register,
    output logic [`IWD_REG_W-1:0]            second_source_register,
    output logic [`IWD_MOD_W-1:0]            source_modifier,
    output logic [`IWD_REG_W-1:0]            destination_register,
    output logic [`IWD_MOD_W-1:0]            destination_modifier,
    output logic                             dest_is_source,
    output logic [`IWD_FILE_W-1:0]           file_address,
    output logic                             dest_working_register_zero,
    output logic [`IWD_LIT_W-1:0]            literal_value,
    output logic [`IWD_BIT_W-1:0]            bit_position,
    output logic                             bit_from_register,
    output logic                             target_is_file,
    output logic                             acc_select_b,
    output logic [`IWD_PF_W-1:0]             x_prefetch,
    output logic [`IWD_PF_W-1:0]             y_prefetch,
    output logic [`IWD_WB_W-1:0]             acc_writeback,
    output logic [`IWD_REG_W-1:0]            shift_amount_register,
    output logic                             shift_from_literal,
    output logic [WORD_W-1:0]                program_address,
    output logic [`IWD_TBL_W-1:0]            table_mode,
    output logic                             timer_increment
);

    initial begin
        if (WORD_W != `IWD_WORD_W) begin
            $error("WORD_W must equal the 24-bit instruction word width");
        end
    end

    localparam int PHASE_CNT = `IWD_TCY_NS / `IWD_CLK_NS;
    initial begin
        if (PHASE_CNT != `IWD_PHASES) begin
            $error("Instruction cycle must be four clock periods");
        end
    end

    // ============================================================
    // Reset release
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ============================================================
    // Functions
    function automatic logic is_double(input logic [`IWD_OPC_W-1:0] opc);
        return (opc == `IWD_OPC_DW0) || (opc == `IWD_OPC_DW1) || (opc == `IWD_OPC_DW2); // RULE2
    endfunction

    function automatic instruction_word_decoder_pkg::instr_class_e
        classify(input logic [`IWD_OPC_W-1:0] opc);
        instruction_word_decoder_pkg::instr_class_e c;
        c = instruction_word_decoder_pkg::CLS_CTRL;
        if (opc == `IWD_OPC_NOP) begin
            c = instruction_word_decoder_pkg::CLS_NOP;                  // RULE4
        end else begin
            unique case (opc[7:4])
                `IWD_CLS_WORD_REG, `IWD_CLS_WORD_REG2:
                    c = instruction_word_decoder_pkg::CLS_WORD_REG;
                `IWD_CLS_FILE:    c = instruction_word_decoder_pkg::CLS_FILE;
                `IWD_CLS_BIT:     c = instruction_word_decoder_pkg::CLS_BIT;
                `IWD_CLS_LIT_MOV: c = instruction_word_decoder_pkg::CLS_LIT_MOV;
                `IWD_CLS_LIT_ALU: c = instruction_word_decoder_pkg::CLS_LIT_ALU;
                `IWD_CLS_MAC:     c = instruction_word_decoder_pkg::CLS_MAC;
                `IWD_CLS_DSP:     c = instruction_word_decoder_pkg::CLS_DSP;
                `IWD_CLS_TBL:     c = instruction_word_decoder_pkg::CLS_TABLE;
                default:          c = instruction_word_decoder_pkg::CLS_CTRL;
            endcase
        end
        return c;
    endfunction

    function automatic logic [`IWD_REG_W-1:0] reg_at(input logic [WORD_W-1:0] w,
                                                     input int lsb);
        return w[lsb +: `IWD_REG_W];
    endfunction

    // ============================================================
    // Four-phase cycle and cycle clock
    logic [1:0] phase_q;

    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            phase_q            <= 2'h0;
            quarter_phase      <= 2'h0;
            cycle_clock_output <= 1'b0;
        end else if (clk_en) begin
            phase_q            <= phase_q + 2'h1;                        // RULE13
            quarter_phase      <= phase_q + 2'h1;
            cycle_clock_output <= (phase_q == 2'h1) || (phase_q == 2'h2); // RULE14
        end
    end

    // ============================================================
    // Fetch sequencing
    instruction_word_decoder_pkg::fetch_state_e fetch_q;
    logic [WORD_W-1:0]                          first_q;
    logic                                       take;

    assign take = clk_en && fetch_valid;

    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            fetch_q <= instruction_word_decoder_pkg::FETCH_FIRST;
            first_q <= '0;
        end else if (take) begin
            unique case (fetch_q)
                instruction_word_decoder_pkg::FETCH_FIRST: begin
                    first_q <= fetch_word;
                    if (is_double(fetch_word[`IWD_OPC_MSB:`IWD_OPC_LSB])) begin
                        fetch_q <= instruction_word_decoder_pkg::FETCH_SECOND; // RULE16
                    end
                end
                instruction_word_decoder_pkg::FETCH_SECOND:
                    fetch_q <= instruction_word_decoder_pkg::FETCH_FIRST;
            endcase
        end
    end

    // ============================================================
    // Field decode
    logic             issue;
    logic [WORD_W-1:0] w;

    assign issue = take && (fetch_q == instruction_word_decoder_pkg::FETCH_SECOND ||
                            !is_double(fetch_word[`IWD_OPC_MSB:`IWD_OPC_LSB]));
    assign w = (fetch_q == instruction_word_decoder_pkg::FETCH_SECOND) ? first_q : fetch_word;

    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            decode_valid <= 1'b0;
        end else if (clk_en) begin
            decode_valid <= issue;
        end
    end

    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            instr_class                <= instruction_word_decoder_pkg::CLS_NOP;
            opcode                     <= '0;
            double_word                <= 1'b0;
            second_word                <= '0;
            second_word_bad            <= 1'b0;
            base_source_register       <= '0;
            second_source_register     <= '0;
            source_modifier            <= '0;
            destination_register       <= '0;
            destination_modifier       <= '0;
            dest_is_source             <= 1'b0;
            file_address               <= '0;
            dest_working_register_zero <= 1'b0;
            literal_value              <= '0;
            bit_position               <= '0;
            bit_from_register          <= 1'b0;
            target_is_file             <= 1'b0;
            acc_select_b               <= 1'b0;
            x_prefetch                 <= '0;
            y_prefetch                 <= '0;
            acc_writeback              <= '0;
            shift_amount_register      <= '0;
            shift_from_literal         <= 1'b0;
            program_address            <= '0;
            table_mode                 <= '0;
        end else if (clk_en && issue) begin
            opcode      <= w[`IWD_OPC_MSB:`IWD_OPC_LSB];                // RULE1
            instr_class <= classify(w[`IWD_OPC_MSB:`IWD_OPC_LSB]);       // RULE4
            double_word <= (fetch_q == instruction_word_decoder_pkg::FETCH_SECOND);
            second_word <= (fetch_q == instruction_word_decoder_pkg::FETCH_SECOND)
                         ? fetch_word : '0;
            // Upper byte of a trailing word must be zero; flagged, not trapped.
            second_word_bad <= (fetch_q == instruction_word_decoder_pkg::FETCH_SECOND)
                             && (fetch_word[`IWD_OPC_MSB:`IWD_OPC_LSB] != 8'h00); // RULE3
            base_source_register   <= reg_at(w, `IWD_BASE_LSB);          // RULE5
            second_source_register <= reg_at(w, `IWD_SRC_LSB);           // RULE5
            source_modifier        <= w[`IWD_SMOD_LSB +: `IWD_MOD_W];    // RULE5
            destination_register   <= reg_at(w, `IWD_DEST_LSB);          // RULE5
            destination_modifier   <= w[`IWD_DMOD_LSB+`IWD_DEST_LSB -: `IWD_MOD_W]; // RULE5
            file_address           <= w[`IWD_FILE_LSB +: `IWD_FILE_W];   // RULE6
            dest_working_register_zero <= !w[`IWD_DIRSEL_BIT];           // RULE6
            literal_value          <= w[`IWD_LIT_LSB +: `IWD_LIT_W];     // RULE8
            bit_position           <= w[`IWD_BIT_LSB +: `IWD_BIT_W];     // RULE7
            bit_from_register      <= w[`IWD_BITIND_BIT];                // RULE7
            target_is_file         <= w[`IWD_DIRSEL_BIT];                // RULE8
            // Literal ALU writes back into the base when no separate destination is coded.
            dest_is_source <= (classify(w[`IWD_OPC_MSB:`IWD_OPC_LSB])
                               == instruction_word_decoder_pkg::CLS_LIT_ALU)
                              && (reg_at(w, `IWD_DEST_LSB) == reg_at(w, `IWD_BASE_LSB)); // RULE9
            acc_select_b           <= w[`IWD_ACC_BIT];                   // RULE10 RULE11
            x_prefetch             <= w[`IWD_XPF_LSB +: `IWD_PF_W];      // RULE10
            y_prefetch             <= w[`IWD_YPF_LSB +: `IWD_PF_W];      // RULE10
            acc_writeback          <= w[`IWD_WB_LSB +: `IWD_WB_W];       // RULE10
            shift_amount_register  <= reg_at(w, `IWD_SRC_LSB);           // RULE11
            shift_from_literal     <= w[`IWD_SHLIT_BIT];                 // RULE11
            table_mode             <= w[`IWD_TBL_LSB +: `IWD_TBL_W];     // RULE12
            program_address        <= (fetch_q == instruction_word_decoder_pkg::FETCH_SECOND)
                                    ? {fetch_word[15:0], w[7:0]} : '0;   // RULE12
        end
    end

    // ============================================================
    // External timer clock
    // Three stages; an edge counts only when the second and third agree on the new level.
    logic [2:0] tck_sync_q;
    logic       tck_level_q;

    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tck_sync_q <= 3'h0;
            tck_level_q <= 1'b0;
        end else if (clk_en) begin
            tck_sync_q <= {tck_sync_q[1:0], timer_external_clock_input};
            if (tck_sync_q[1] == tck_sync_q[2]) begin
                tck_level_q <= tck_sync_q[2];
            end
        end
    end

    // The pulse follows the qualified edge at once: waiting for a phase boundary
    // as well would push the worst case past 1.5 instruction cycles.
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            timer_increment <= 1'b0;
        end else if (clk_en) begin
            timer_increment <= tck_sync_q[1] && tck_sync_q[2] && !tck_level_q; // RULE15
        end
    end

endmodule

/* inc/instruction_word_decoder_cfg.svh */
`ifndef INSTRUCTION_WORD_DECODER_CFG_SVH
`define INSTRUCTION_WORD_DECODER_CFG_SVH

// ============================================================
// Word layout
`define IWD_WORD_W        24
`define IWD_OPC_MSB       23
`define IWD_OPC_LSB       16
`define IWD_OPC_W         8
`define IWD_DEST_LSB      7
`define IWD_BASE_LSB      11
`define IWD_SRC_LSB       0
`define IWD_DMOD_LSB      4
`define IWD_SMOD_LSB      4
`define IWD_REG_W         4
`define IWD_MOD_W         3
`define IWD_FILE_W        13
`define IWD_FILE_LSB      0
`define IWD_DIRSEL_BIT    14
`define IWD_LIT_W         10
`define IWD_LIT_LSB       4
`define IWD_BIT_LSB       12
`define IWD_BIT_W         4
`define IWD_BITIND_BIT    15
`define IWD_ACC_BIT       15
`define IWD_WB_LSB        0
`define IWD_WB_W          2
`define IWD_XPF_LSB       2
`define IWD_YPF_LSB       7
`define IWD_PF_W          5
`define IWD_SHLIT_BIT     15
`define IWD_TBL_LSB       14
`define IWD_TBL_W         2

// Opcode class ranges: upper nibble of the opcode.
`define IWD_CLS_WORD_REG  4'h4
`define IWD_CLS_WORD_REG2 4'h5
`define IWD_CLS_FILE      4'hE
`define IWD_CLS_BIT       4'hA
`define IWD_CLS_LIT_MOV   4'h2
`define IWD_CLS_LIT_ALU   4'hB
`define IWD_CLS_MAC       4'hC
`define IWD_CLS_DSP       4'hD
`define IWD_CLS_CTRL      4'h0
`define IWD_CLS_TBL       4'h8

// The three double-word opcodes and the no-operation opcode.
`define IWD_OPC_DW0       8'h02
`define IWD_OPC_DW1       8'h04
`define IWD_OPC_DW2       8'h08
`define IWD_OPC_NOP       8'h00

// ============================================================
// Timing
`define IWD_PHASES        4
`define IWD_TCY_NS        40
`define IWD_CLK_NS        10

`endif

/* inc/instruction_word_decoder_pkg.sv */
package instruction_word_decoder_pkg;
    typedef enum logic [3:0] {
        CLS_NOP,
        CLS_WORD_REG,
        CLS_FILE,
        CLS_BIT,
        CLS_LIT_MOV,
        CLS_LIT_ALU,
        CLS_MAC,
        CLS_DSP,
        CLS_CTRL,
        CLS_TABLE
    } instr_class_e;

    typedef enum logic {
        FETCH_FIRST,
        FETCH_SECOND
    } fetch_state_e;
endpackage

/* sim/instruction_word_decoder_assertions.sv */
`include "instruction_word_decoder_cfg.svh"

// ============================================================
// Checker
module instruction_word_decoder_checker (
    input wire logic                                   mclk,
    input wire logic                                   nrst,
    input wire logic                                   clk_en,
    input wire logic [`IWD_WORD_W-1:0]                 fetch_word,
    input wire logic                                   fetch_valid,
    input wire logic                                   timer_external_clock_input,
    input wire logic                                   cycle_clock_output,
    input wire logic [1:0]                             quarter_phase,
    input wire logic                                   decode_valid,
    input wire instruction_word_decoder_pkg::instr_class_e instr_class,
    input wire logic [`IWD_OPC_W-1:0]                  opcode,
    input wire logic                                   double_word,
    input wire logic                                   second_word_bad,
    input wire logic                                   timer_increment
);
    logic [3:0]             live_q;
    logic                   pend_q;
    logic [`IWD_WORD_W-1:0] first_q;
    logic [`IWD_WORD_W-1:0] sec_q;
    wire logic take = clk_en && fetch_valid;
    wire logic dw = fetch_word[`IWD_OPC_MSB:`IWD_OPC_LSB] inside
        {`IWD_OPC_DW0, `IWD_OPC_DW1, `IWD_OPC_DW2};

    // The design releases its reset two edges late, so checks wait until it runs.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            live_q <= 4'h0;
        end else begin
            live_q <= {live_q[2:0], 1'b1};
        end
    end
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pend_q <= 1'b0;
        end else if (take) begin
            pend_q <= !pend_q && dw;
        end
    end
    always_ff @(posedge mclk) begin
        if (take && !pend_q) begin
            first_q <= fetch_word;
        end
        if (take && pend_q) begin
            sec_q <= fetch_word;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst || !live_q[3]);

    AST_SINGLE_LAT: assert property (take && !pend_q && !dw |=> decode_valid && !double_word)
        else $error("single word did not decode one cycle later");
    AST_DW_HOLD: assert property (take && !pend_q && dw |=> !decode_valid)
        else $error("first word of a pair decoded alone");
    AST_DW_LAT: assert property (take && pend_q |=> decode_valid && double_word)
        else $error("pair did not decode after its second word");
    AST_OPCODE: assert property (decode_valid |-> opcode == first_q[23:16])
        else $error("opcode is not the top byte of the first word");
    AST_SEC_TOP: assert property (decode_valid && double_word |-> second_word_bad == (sec_q[23:16] != 8'h00))
        else $error("second word top byte flag wrong");
    AST_LONE_NOP: assert property (decode_valid && first_q[23:16] == 8'h00 |->
        instr_class == instruction_word_decoder_pkg::CLS_NOP)
        else $error("zero top byte word did not decode as no operation");
    AST_PHASE: assert property (quarter_phase == 2'($past(quarter_phase) + $past(clk_en)))
        else $error("quarter phase did not step once per enabled cycle");
    AST_CYCLE_CLOCK_OUTPUT: assert property ($past(clk_en) |->
        cycle_clock_output == ($past(quarter_phase) inside {2'h1, 2'h2}))
        else $error("cycle clock level wrong for phase");
    AST_TIMER: assert property ($rose(timer_external_clock_input) |-> ##[2:6] timer_increment)
        else $error("timer did not increment after external edge");
    AST_TIMER_PULSE: assert property (timer_increment |=> !timer_increment)
        else $error("timer increment longer than one cycle");

    COV_PAIR: cover property (take && pend_q);
    COV_NOP: cover property (decode_valid && instr_class == instruction_word_decoder_pkg::CLS_NOP);
    COV_TIMER: cover property (timer_increment);
endmodule

bind instruction_word_decoder instruction_word_decoder_checker i_chk (
    .mclk, .nrst, .clk_en, .fetch_word, .fetch_valid, .timer_external_clock_input,
    .cycle_clock_output, .quarter_phase, .decode_valid, .instr_class, .opcode,
    .double_word, .second_word_bad, .timer_increment
);

/* sim/prog_word_source.sv */
// ============================================================
// Program memory word source
module prog_word_source (
    input wire logic         mclk,
    input wire logic         clk_en,
    input wire logic         slow,
    output logic [23:0]      fetch_word,
    output logic             fetch_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] q[$];
    logic        gap;

    task automatic push(input logic [23:0] w);
        q.push_back(w);
    endtask

    initial begin
        fetch_word = 24'h000000;
        fetch_valid = 1'b0;
        gap = 1'b0;
    end

    // Idle data flips every cycle so a stale word can never look valid.
    always @(posedge mclk) begin
        if (fetch_valid && !clk_en) begin
            gap <= gap;
        end else if (q.size() != 0 && !gap) begin
            fetch_word <= q.pop_front();
            fetch_valid <= 1'b1;
            gap <= slow;
        end else begin
            fetch_word <= ~fetch_word;
            fetch_valid <= 1'b0;
            gap <= 1'b0;
        end
    end
endmodule

/* sim/tb.sv */
`define CHK(nm, ex, sn) begin n_tests++; if ((sn) !== (ex)) begin mismatches++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, ex, sn); end end

// ============================================================
// Testbench
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk, nrst, clk_en, slow, tin, fetch_valid;
    logic [23:0] fetch_word, second_word, program_address;
    logic        cycle_clock_output, decode_valid, double_word, second_word_bad;
    logic        acc_select_b, shift_from_literal, timer_increment;
    logic [1:0]  quarter_phase, table_mode;
    logic [7:0]  opcode;
    logic [3:0]  base_source_register, second_source_register, bit_position;
    logic [12:0] file_address;
    logic [9:0]  literal_value;
    logic        dwz, dis, bfr, tif;
    logic [4:0]  xpf, ypf;
    logic [3:0]  dst, sar;
    logic [2:0]  smod, dmod;
    logic [1:0]  awb;
    int          mismatches, n_tests;
    instruction_word_decoder_pkg::instr_class_e instr_class;

    instruction_word_decoder i_instruction_word_decoder (
        .mclk, .nrst, .clk_en, .fetch_word, .fetch_valid,
        .timer_external_clock_input(tin), .cycle_clock_output, .quarter_phase,
        .decode_valid, .instr_class, .opcode, .double_word, .second_word,
        .second_word_bad, .base_source_register, .second_source_register,
        .source_modifier(smod), .destination_register(dst), .destination_modifier(dmod),
        .dest_is_source(dis), .file_address, .dest_working_register_zero(dwz),
        .literal_value, .bit_position, .bit_from_register(bfr), .target_is_file(tif),
        .acc_select_b, .x_prefetch(xpf), .y_prefetch(ypf), .acc_writeback(awb),
        .shift_amount_register(sar), .shift_from_literal, .program_address,
        .table_mode, .timer_increment
    );
    prog_word_source i_prog_word_source (.mclk, .clk_en, .slow, .fetch_word, .fetch_valid);

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wait_dec();
        for (int i = 0; i < 40; i++) begin
            @(posedge mclk);
            #1;
            if (decode_valid === 1'b1) return;
        end
        mismatches++;
        $display("[FAIL] decode_valid expected 1 seen 0");
        print_verdict();
    endtask

    // Words go back to back so every decode pulse lands in consecutive cycles.
    task automatic s_classes();
        logic [23:0] w[10] = '{24'h415A3C, 24'h5F8001, 24'hE01FFF, 24'hA3F000, 24'h2D3FF0,
                               24'hB20010, 24'hC1D6B7, 24'hD28005, 24'h01C000, 24'h80C000};
        instruction_word_decoder_pkg::instr_class_e c[10] = '{
            instruction_word_decoder_pkg::CLS_WORD_REG, instruction_word_decoder_pkg::CLS_WORD_REG,
            instruction_word_decoder_pkg::CLS_FILE, instruction_word_decoder_pkg::CLS_BIT,
            instruction_word_decoder_pkg::CLS_LIT_MOV, instruction_word_decoder_pkg::CLS_LIT_ALU,
            instruction_word_decoder_pkg::CLS_MAC, instruction_word_decoder_pkg::CLS_DSP,
            instruction_word_decoder_pkg::CLS_CTRL, instruction_word_decoder_pkg::CLS_TABLE};
        foreach (w[i]) i_prog_word_source.push(w[i]);
        foreach (w[i]) begin
            wait_dec();
            `CHK("instr_class", c[i], instr_class)
            `CHK("opcode", w[i][23:16], opcode)
            case (i)
                0, 1: `CHK("second_src", w[i][3:0], second_source_register)
                2: `CHK("file_address", w[i][12:0], file_address)
                3: `CHK("bit_position", w[i][15:12], bit_position)
                4: `CHK("literal_mov", w[i][13:4], literal_value)
                5: `CHK("literal_alu", w[i][13:4], literal_value)
                6: `CHK("acc_select_b", w[i][15], acc_select_b)
                7: `CHK("shift_from_literal", w[i][15], shift_from_literal)
                8: `CHK("ctrl_opcode", 8'h01, opcode)
                default: `CHK("table_mode", w[i][15:14], table_mode)
            endcase
            if (i < 2) begin
                `CHK("base_src", w[i][14:11], base_source_register)
                `CHK("dest_reg", w[i][10:7], dst)
                `CHK("src_mod", w[i][6:4], smod)
                `CHK("dest_mod", w[i][11:9], dmod)
            end
            if (i == 2) `CHK("dest_wreg0", !w[i][14], dwz)
            if (i == 3) `CHK("bit_from_reg", w[i][15], bfr)
            if (i == 4) `CHK("target_file", w[i][14], tif)
            if (i == 5) `CHK("dest_is_src", 1'b1, dis)
            if (i == 6) `CHK("x_prefetch", w[i][6:2], xpf)
            if (i == 6) `CHK("y_prefetch", w[i][11:7], ypf)
            if (i == 6) `CHK("acc_wb", w[i][1:0], awb)
            if (i == 7) `CHK("shift_reg", w[i][3:0], sar)
        end
    endtask

    task automatic s_double(input logic [23:0] w1, input logic [23:0] w2, input logic sl);
        slow <= sl;
        i_prog_word_source.push(w1);
        i_prog_word_source.push(w2);
        wait_dec();
        `CHK("double_word", 1'b1, double_word)
        `CHK("second_word", w2, second_word)
        `CHK("program_address", {w2[15:0], w1[7:0]}, program_address)
        `CHK("second_word_bad", |w2[23:16], second_word_bad)
        slow <= 1'b0;
    endtask

    task automatic s_lone();
        i_prog_word_source.push(24'h00BEEF);
        wait_dec();
        `CHK("lone_class", instruction_word_decoder_pkg::CLS_NOP, instr_class)
        `CHK("lone_double", 1'b0, double_word)
    endtask

    task automatic s_clock();
        logic [1:0] p;
        int         hi;
        hi = 0;
        @(posedge mclk);
        #1;
        p = quarter_phase;
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk);
            #1;
            `CHK("quarter_phase", p + 2'h1, quarter_phase)
            `CHK("cycle_clock", p inside {2'h1, 2'h2}, cycle_clock_output)
            hi += cycle_clock_output;
            p = quarter_phase;
        end
        `CHK("clock_high_count", 4, hi)
        @(posedge mclk) clk_en <= 1'b0;
        #1;
        p = quarter_phase;
        repeat (3) @(posedge mclk);
        #1;
        `CHK("frozen_phase", p, quarter_phase)
        @(posedge mclk) clk_en <= 1'b1;
    endtask

    // The pin stays high long enough for the slowest legal synchroniser path.
    task automatic s_timer(input int off);
        int n;
        repeat (off) @(posedge mclk);
        @(posedge mclk) tin <= 1'b1;
        n = 0;
        while (timer_increment !== 1'b1 && n < 12) begin
            @(posedge mclk);
            #1;
            n++;
        end
        `CHK("timer_delay_ok", 1'b1, n >= 2 && n <= 6)
        if (n >= 12) print_verdict();
        repeat (6) @(posedge mclk);
        @(posedge mclk) tin <= 1'b0;
        repeat (12) @(posedge mclk);
    endtask

    initial begin
        nrst = 1'b0;
        clk_en = 1'b1;
        slow = 1'b0;
        tin = 1'b0;
        mismatches = 0;
        n_tests = 0;
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        s_classes();
        s_double(24'h02ABCD, 24'h001234, 1'b0);
        s_double(24'h0455AA, 24'h00FFFF, 1'b1);
        s_double(24'h0800FF, 24'h00C3A5, 1'b0);
        s_double(24'h021111, 24'h7E2222, 1'b0);
        s_lone();
        s_clock();
        for (int k = 0; k < 3; k++) s_timer(k);
        print_verdict();
    end
endmodule
